/* File: bench/clk_cond_asserts.sv */
`timescale 1ns/1ps
// Watches the divider ports; all checks share the sample clock
module clk_cond_asserts #(
  parameter int SAMPLE_W = 10
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  // Reference select and sample path
  input wire logic REF_SENSE_AT_SUPPLY,
  input wire logic [SAMPLE_W-1:0] SAMPLE_IN,
  input wire logic [SAMPLE_W-1:0] SAMPLE_OUT,
  input wire logic SAMPLE_STROBE,
  input wire logic DIV_CLK,
  input wire logic INTERNAL_REF_EN,
  input wire logic RESTORER_LOCKED
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  logic [7:0] wait_reg, wait_next;
  // Cycles since the relock wait last restarted; saturates so it never wraps
  always_comb begin
    wait_next = (wait_reg == 8'hff) ? wait_reg : wait_reg + 8'h01;
    if (REG_WR && (REG_ADDR == 8'h0b || REG_ADDR == 8'h09)) begin
      wait_next = 8'h00;
    end
  end
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      wait_reg <= 8'h00;
    end else begin
      wait_reg <= wait_next;
    end
  end
  // A ratio write is the first step of a fresh relock
  sequence s_ratio_write;
    REG_WR && REG_ADDR == clk_cond_pkg::ADDR_DIVIDER;
  endsequence
  strobe_period_a: assert property (SAMPLE_STROBE |-> ##[1:8] SAMPLE_STROBE)
    else $error("divided period longer than eight");
  clk_rise_sample_a: assert property ($rose(DIV_CLK) |-> SAMPLE_STROBE)
    else $error("divided clock rose without a sample");
  sample_capture_a: assert property (SAMPLE_STROBE |-> SAMPLE_OUT == $past(SAMPLE_IN))
    else $error("sample not taken at the strobe edge");
  sample_hold_a: assert property ($past(RST_N) && !SAMPLE_STROBE |-> $stable(SAMPLE_OUT))
    else $error("sample changed between strobes");
  ref_select_a: assert property ($past(RST_N) |->
    INTERNAL_REF_EN == !$past(REF_SENSE_AT_SUPPLY))
    else $error("reference choice does not follow sense");
  ratio_one_a: assert property (SAMPLE_STROBE ##1 SAMPLE_STROBE |-> DIV_CLK)
    else $error("back to back samples without clock high");
  duty_high_a: assert property ((DIV_CLK && !SAMPLE_STROBE) [*3] |=> !DIV_CLK || SAMPLE_STROBE)
    else $error("divided clock high too long");
  lock_wait_a: assert property ($rose(RESTORER_LOCKED) |-> wait_reg >= 8'd30)
    else $error("restorer locked before the relock wait");
  relock_drop_a: assert property (s_ratio_write |-> ##[1:2] !RESTORER_LOCKED)
    else $error("ratio change kept the lock flag");
endmodule
bind sample_clock_divider_sync clk_cond_asserts #(.SAMPLE_W(SAMPLE_W)) i_chk (
  .MCLK(MCLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REF_SENSE_AT_SUPPLY(REF_SENSE_AT_SUPPLY), .SAMPLE_IN(SAMPLE_IN), .SAMPLE_OUT(SAMPLE_OUT),
  .SAMPLE_STROBE(SAMPLE_STROBE), .DIV_CLK(DIV_CLK), .INTERNAL_REF_EN(INTERNAL_REF_EN),
  .RESTORER_LOCKED(RESTORER_LOCKED));

/* File: bench/sample_clock_divider_sync_test.sv */
`timescale 1ns/1ps
module sample_clock_divider_sync_test;
  logic mclk = 0, rst_n = 0, wr = 0, rd = 0, rd_d = 0, ref_sup = 0, fire = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [9:0] s_in = 10'h000;
  logic [9:0] s_in_d = 10'h000;
  logic ref_d = 0;
  logic [31:0] seed = 32'h1;
  logic [7:0] exp_q[$];
  wire logic [7:0] rdata;
  wire logic [9:0] s_out;
  wire logic sync, strobe, dclk, iref, locked;
  int fails = 0, n_tests = 0;
  // Clock
  always #25 mclk = ~mclk;
  sample_clock_divider_sync i_dut (.MCLK(mclk), .RST_N(rst_n), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .SYNC_IN(sync),
    .REF_SENSE_AT_SUPPLY(ref_sup), .SAMPLE_IN(s_in), .SAMPLE_OUT(s_out),
    .SAMPLE_STROBE(strobe), .DIV_CLK(dclk), .INTERNAL_REF_EN(iref), .RESTORER_LOCKED(locked));
  sync_pulse_source i_src (.clk(mclk), .fire(fire), .sync_out(sync));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    exp_q.push_back(exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
  endtask
  // Period and high time up to the next strobe; bounded so a stuck divider ends the run
  task automatic next_strobe(output int n, output int hi);
    n = 0;
    hi = 0;
    do begin
      @(posedge mclk);
      n++;
      hi += (dclk === 1'b1) ? 1 : 0;
    end while (strobe !== 1'b1 && n < 40);
    if (n >= 40) begin
      fails++;
      end_sim();
    end
  endtask
  // Pulse right after a strobe: accepted shows in 5 cycles, ignored keeps 8
  task automatic sync_try(input logic [7:0] exp);
    int n, hi;
    next_strobe(n, hi);
    fire <= 1'b1;
    next_strobe(n, hi);
    fire <= 1'b0;
    check("sync delay", exp, 8'(n));
  endtask
  // Read data stands only in the cycle after the read strobe, so compare there
  always @(posedge mclk) begin
    if (rd_d) check("read data", exp_q.pop_front(), rdata);
    // A strobe carries the word and reference sense of the previous edge
    if (strobe === 1'b1) begin
      check("sample lo", s_in_d[7:0], s_out[7:0]);
      check("sample hi", {6'h00, s_in_d[9:8]}, {6'h00, s_out[9:8]});
      check("int ref", {7'h00, !ref_d}, {7'h00, iref});
    end
    rd_d <= rd;
    s_in_d <= s_in;
    ref_d <= ref_sup;
  end
  // Fresh sample word and reference sense every cycle
  always @(posedge mclk) begin
    seed <= xs(seed);
    s_in <= seed[9:0];
    ref_sup <= seed[20];
  end
  initial begin
    int n, hi;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rd_reg(8'h09, 8'h01);
    rd_reg(8'h0b, 8'h00);
    rd_reg(8'h3a, 8'h00);
    rd_reg(8'h55, 8'h00);
    for (int r = 0; r < 8; r++) begin
      wr_reg(8'h0b, 8'(r));
      rd_reg(8'h0b, 8'(r));
      repeat (2) next_strobe(n, hi);
      check("period", 8'(r + 1), 8'(n));
      check("high time", 8'(r / 2 + 1), 8'(hi));
    end
    wr_reg(8'h09, 8'h00);
    repeat (2) next_strobe(n, hi);
    check("high off", 8'h01, 8'(hi));
    check("locked off", 8'h00, {7'h00, locked});
    wr_reg(8'h09, 8'h01);
    repeat (110) @(posedge mclk);
    check("locked", 8'h01, {7'h00, locked});
    wr_reg(8'h0b, 8'h07);
    @(posedge mclk);
    check("relock", 8'h00, {7'h00, locked});
    wr_reg(8'h3a, 8'h00);
    sync_try(8'h08);
    wr_reg(8'h3a, 8'h02);
    sync_try(8'h05);
    sync_try(8'h05);
    wr_reg(8'h3a, 8'h06);
    rd_reg(8'h3a, 8'h06);
    sync_try(8'h05);
    sync_try(8'h08);
    wr_reg(8'h3a, 8'h06);
    sync_try(8'h05);
    end_sim();
  end
endmodule

/* File: bench/sync_pulse_source.sv */
`timescale 1ns/1ps
// Timing controller: launches the pulse on the rising edge so every device
// captures it at the same clock edge
module sync_pulse_source (
  // Clock and request
  input wire logic clk,
  input wire logic fire,
  // Pulse to the device
  output logic sync_out = 1'b0
);
  logic fire_d = 1'b0;
  // One cycle high per request, then low again
  always @(posedge clk) begin
    fire_d <= fire;
    sync_out <= fire && !fire_d;
  end
endmodule

/* File: hdl/clk_cond_pkg.sv */
package clk_cond_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_RESTORER_CTRL = 8'h09;
  localparam logic [7:0] ADDR_DIVIDER = 8'h0b;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_SYNC_CTRL = 8'h3a;

  // Field positions
  localparam int RESTORER_EN_BIT = 0;
  localparam int SYNC_EN_BIT = 1;
  localparam int SYNC_ONCE_BIT = 2;
  localparam int STAT_LOCKED_BIT = 0;
  localparam int STAT_INT_REF_BIT = 1;
  localparam int STAT_ARMED_BIT = 2;
  localparam int STAT_ACTIVE_BIT = 3;
  localparam int STAT_COUNT_LSB = 4;

  // Values after reset
  localparam logic [2:0] RATIO_M1_RESET = 3'h0;
  localparam logic RESTORER_EN_RESET = 1'b1;
  localparam logic SYNC_EN_RESET = 1'b0;
  localparam logic SYNC_ONCE_RESET = 1'b0;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLK_FREQ_HZ = 20000000;
  localparam int RESTORER_MIN_HZ = 20000000;
  localparam int RELOCK_MIN_NS = 1500;
  localparam int RELOCK_MAX_NS = 5000;
  localparam int RELOCK_CYCLES = (RELOCK_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELOCK_CNT_W = 12;

  // Duty restorer lock tracking
  typedef enum logic [2:0] {
    RESTORER_OFF = 3'b001,
    RESTORER_SETTLE = 3'b010,
    RESTORER_LOCKED = 3'b100
  } restorer_state_type;

endpackage

/* File: hdl/sample_clock_divider_sync.sv */
`timescale 1ns/1ps
// Function
// R01 - Divide the sample clock by an integer ratio from one to eight.
// R02 - An accepted alignment pulse returns the divider to its initial state.
// R03 - Bits 1 and 2 of 0x3A pick realign on every pulse or first after write.
// R04 - The alignment pulse passes a sample-clock synchronizer before resetting the divider.
// R05 - The controller drives the alignment pulse synchronous to the input clock.
// R06 - With the restorer on, the divided clock is regenerated near 50% duty.
// R07 - Below a nominal 20 MHz no duty correction is guaranteed.
// R08 - After a rate change the system waits 1.5 to 5 us for relock.
// R09 - The reference-select comparator picks internal or external reference.
// R10 - Each new sample is taken on the rising edge of the divided clock; at ratio one DIV_CLK stays high and samples come with no rising edge.
// R11 - Ratio is held as ratio minus one; ratio one passes every input cycle.
module sample_clock_divider_sync #(
  parameter int SAMPLE_W = 10,
  parameter int CLK_FREQ_HZ = clk_cond_pkg::CLK_FREQ_HZ
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Alignment and reference select
  input wire logic SYNC_IN,
  input wire logic REF_SENSE_AT_SUPPLY,
  // Sample path
  input wire logic [SAMPLE_W-1:0] SAMPLE_IN,
  output logic [SAMPLE_W-1:0] SAMPLE_OUT,
  output logic SAMPLE_STROBE,
  output logic DIV_CLK,
  // Status
  output logic INTERNAL_REF_EN,
  output logic RESTORER_LOCKED
);

  // Restorer can only be trusted at or above its minimum input rate
  localparam logic RATE_OK = (CLK_FREQ_HZ >= clk_cond_pkg::RESTORER_MIN_HZ);

  logic [2:0] ratio_m1_reg, ratio_m1_next;
  logic restorer_en_reg, restorer_en_next;
  logic sync_en_reg, sync_en_next;
  logic sync_once_reg, sync_once_next;
  logic sync_armed_reg, sync_armed_next;
  logic sync_meta_reg, sync_stage_reg, sync_prev_reg;
  logic [2:0] count_reg, count_next;
  logic strobe_reg, strobe_next;
  logic div_clk_reg, div_clk_next;
  logic [SAMPLE_W-1:0] sample_reg, sample_next;
  logic int_ref_reg, int_ref_next;
  logic [7:0] rdata_reg, rdata_next;
  clk_cond_pkg::restorer_state_type rst_state_reg, rst_state_next;
  logic [clk_cond_pkg::RELOCK_CNT_W-1:0] relock_cnt_reg, relock_cnt_next;
  logic locked_reg, locked_next;

  logic wr_restorer, wr_divider, wr_sync;
  logic sync_edge, sync_accept, restorer_active;
  logic [2:0] high_len;

  // Address decode for writes
  assign wr_restorer = REG_WR && (REG_ADDR == clk_cond_pkg::ADDR_RESTORER_CTRL);
  assign wr_divider = REG_WR && (REG_ADDR == clk_cond_pkg::ADDR_DIVIDER);
  assign wr_sync = REG_WR && (REG_ADDR == clk_cond_pkg::ADDR_SYNC_CTRL);

  // Pulse edge is seen only from the second stage onward
  assign sync_edge = sync_stage_reg && !sync_prev_reg; // [R04]
  assign sync_accept = sync_edge && sync_en_reg && (!sync_once_reg || sync_armed_reg); // [R03]
  assign restorer_active = restorer_en_reg && RATE_OK; // [R07]

  // Control registers and one-shot arming
  always_comb begin
    ratio_m1_next = ratio_m1_reg;
    restorer_en_next = restorer_en_reg;
    sync_en_next = sync_en_reg;
    sync_once_next = sync_once_reg;
    sync_armed_next = sync_armed_reg;
    if (wr_divider) begin
      ratio_m1_next = REG_WDATA[2:0]; // [R11]
    end
    if (wr_restorer) begin
      restorer_en_next = REG_WDATA[clk_cond_pkg::RESTORER_EN_BIT];
    end
    if (sync_accept) begin
      sync_armed_next = 1'b0;
    end
    // A write re-arms even when a pulse is accepted in the same cycle
    if (wr_sync) begin
      sync_en_next = REG_WDATA[clk_cond_pkg::SYNC_EN_BIT]; // [R03]
      sync_once_next = REG_WDATA[clk_cond_pkg::SYNC_ONCE_BIT]; // [R03]
      sync_armed_next = 1'b1; // [R03]
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ratio_m1_reg <= clk_cond_pkg::RATIO_M1_RESET;
      restorer_en_reg <= clk_cond_pkg::RESTORER_EN_RESET;
      sync_en_reg <= clk_cond_pkg::SYNC_EN_RESET;
      sync_once_reg <= clk_cond_pkg::SYNC_ONCE_RESET;
      sync_armed_reg <= 1'b0;
    end else begin
      ratio_m1_reg <= ratio_m1_next;
      restorer_en_reg <= restorer_en_next;
      sync_en_reg <= sync_en_next;
      sync_once_reg <= sync_once_next;
      sync_armed_reg <= sync_armed_next;
    end
  end

  // Two-stage synchronizer plus edge history for the alignment pulse
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sync_meta_reg <= 1'b0;
      sync_stage_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
    end else begin
      sync_meta_reg <= SYNC_IN; // [R04]
      sync_stage_reg <= sync_meta_reg; // [R04]
      sync_prev_reg <= sync_stage_reg;
    end
  end

  // Divider counter, sample strobe and divided clock level
  always_comb begin
    // Odd ratios round the high phase up; without the restorer it is one cycle
    high_len = restorer_active ? 3'((4'(ratio_m1_reg) + 4'h2) >> 1) : 3'h1; // [R06]
    if (sync_accept) begin
      count_next = 3'h0; // [R02]
    end else if (count_reg >= ratio_m1_reg) begin
      count_next = 3'h0; // [R01]
    end else begin
      count_next = count_reg + 3'h1; // [R01]
    end
    strobe_next = (count_next == 3'h0); // [R10]
    // Level may only rise with a sample; a mid-period restorer or ratio change
    // can shorten the high phase but never create an extra rising edge.
    // Ratio one strobes every cycle, so the level stays high.
    div_clk_next = strobe_next || (div_clk_reg && (count_next < high_len)); // [R06] [R11]
    sample_next = strobe_next ? SAMPLE_IN : sample_reg; // [R10]
    int_ref_next = !REF_SENSE_AT_SUPPLY; // [R09]
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      count_reg <= 3'h0;
      strobe_reg <= 1'b0;
      div_clk_reg <= 1'b0;
      sample_reg <= '0;
      int_ref_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      strobe_reg <= strobe_next;
      div_clk_reg <= div_clk_next;
      sample_reg <= sample_next;
      int_ref_reg <= int_ref_next;
    end
  end

  // Relock tracking: any ratio or restorer change restarts the wait
  always_comb begin
    rst_state_next = rst_state_reg;
    relock_cnt_next = relock_cnt_reg;
    unique case (rst_state_reg)
      clk_cond_pkg::RESTORER_OFF: begin
        if (restorer_active) begin
          rst_state_next = clk_cond_pkg::RESTORER_SETTLE;
          relock_cnt_next = '0;
        end
      end
      clk_cond_pkg::RESTORER_SETTLE: begin
        if (!restorer_active) begin
          rst_state_next = clk_cond_pkg::RESTORER_OFF;
        end else if (wr_divider) begin
          relock_cnt_next = '0; // [R08]
        end else if (relock_cnt_reg >=
                     clk_cond_pkg::RELOCK_CNT_W'(clk_cond_pkg::RELOCK_CYCLES - 1)) begin
          rst_state_next = clk_cond_pkg::RESTORER_LOCKED; // [R08]
        end else begin
          relock_cnt_next = relock_cnt_reg + clk_cond_pkg::RELOCK_CNT_W'(1);
        end
      end
      clk_cond_pkg::RESTORER_LOCKED: begin
        if (!restorer_active) begin
          rst_state_next = clk_cond_pkg::RESTORER_OFF;
        end else if (wr_divider) begin
          rst_state_next = clk_cond_pkg::RESTORER_SETTLE; // [R08]
          relock_cnt_next = '0;
        end
      end
      default: begin
        rst_state_next = clk_cond_pkg::RESTORER_OFF;
      end
    endcase
    locked_next = (rst_state_next == clk_cond_pkg::RESTORER_LOCKED);
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_state_reg <= clk_cond_pkg::RESTORER_OFF;
      relock_cnt_reg <= '0;
      locked_reg <= 1'b0;
    end else begin
      rst_state_reg <= rst_state_next;
      relock_cnt_reg <= relock_cnt_next;
      locked_reg <= locked_next;
    end
  end

  // Read data stands only in the cycle after the read strobe; unmapped reads zero
  always_comb begin
    rdata_next = 8'h00;
    if (REG_RD) begin
      unique case (REG_ADDR)
        clk_cond_pkg::ADDR_RESTORER_CTRL: begin
          rdata_next[clk_cond_pkg::RESTORER_EN_BIT] = restorer_en_reg;
        end
        clk_cond_pkg::ADDR_DIVIDER: begin
          rdata_next[2:0] = ratio_m1_reg;
        end
        clk_cond_pkg::ADDR_SYNC_CTRL: begin
          rdata_next[clk_cond_pkg::SYNC_EN_BIT] = sync_en_reg;
          rdata_next[clk_cond_pkg::SYNC_ONCE_BIT] = sync_once_reg;
        end
        clk_cond_pkg::ADDR_STATUS: begin
          rdata_next[clk_cond_pkg::STAT_LOCKED_BIT] = locked_reg;
          rdata_next[clk_cond_pkg::STAT_INT_REF_BIT] = int_ref_reg;
          rdata_next[clk_cond_pkg::STAT_ARMED_BIT] = sync_armed_reg;
          rdata_next[clk_cond_pkg::STAT_ACTIVE_BIT] = restorer_active;
          rdata_next[clk_cond_pkg::STAT_COUNT_LSB +: 3] = count_reg;
        end
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Outputs straight from flip-flops
  assign REG_RDATA = rdata_reg;
  assign SAMPLE_OUT = sample_reg;
  assign SAMPLE_STROBE = strobe_reg;
  assign DIV_CLK = div_clk_reg;
  assign INTERNAL_REF_EN = int_ref_reg;
  assign RESTORER_LOCKED = locked_reg;

endmodule
